// ### hdl/psi_interlock.sv
// What this block does
// - PWM held off until arm rising edge
// - Disabled PWM outputs sit at passive level
// - Enable pin level follows selected polarity
// - Enable pin never gates the PWM
// - Interlock absent means PWM always enabled
// - Seven trip lines, each ignore or shutdown
// - Trip forces inactive and fault levels
// - Trips latched, cleared by disable-enable cycle
// - Enable pin asserts at once on arming
// - PWM stays off 100 ms after arming
// - Status low while settling, rises with PWM
// - Enable pin assigned or left undriven
`timescale 1ns/10ps
`default_nettype none
`include "psi_map.svh"

module psi_interlock #(
  parameter int NUM_PWM = 6,
  parameter int NUM_HR = 6,
  parameter int NUM_TRIP = 7,
  parameter bit INTERLOCK_PRESENT = 1'b1,
  parameter int unsigned SETTLE_CYC = `PSI_SETTLE_CYC
) (
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic sys_rst_i,
  // Register port
  input wire logic [7:0] reg_addr_i,
  input wire logic [31:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [31:0] reg_rdata_o,
  // Arm and trip inputs from pins
  input wire logic arm_i,
  input wire logic [NUM_TRIP-1:0] trip_i,
  // PWM path
  input wire logic [NUM_PWM-1:0] pwm_i,
  input wire logic [NUM_PWM-1:0] pwm_passive_i,
  output logic [NUM_PWM-1:0] pwm_o,
  input wire logic [NUM_HR-1:0] high_res_pwm_timer_i,
  input wire logic [NUM_HR-1:0] high_res_pwm_timer_passive_i,
  input wire logic [NUM_HR-1:0] high_res_pwm_timer_fault_i,
  input wire logic [NUM_HR-1:0] high_res_pwm_timer_fault_hiz_i,
  output logic [NUM_HR-1:0] high_res_pwm_timer_o,
  output logic [NUM_HR-1:0] high_res_pwm_timer_oe_n_o,
  // Status and gate driver enable
  output logic status_o,
  output logic gde_o,
  output logic gde_oe_n_o,
  output logic irq_o
);

  localparam int CW = $clog2(SETTLE_CYC + 1);

  // ==========================================================
  // Input synchronisers
  // ==========================================================
  // Three stages; a change counts when stages two and three agree
  logic [NUM_TRIP:0] s1_q, s2_q, s3_q, flt_q;
  logic [NUM_TRIP:0] s1_d, s2_d, s3_d, flt_d;
  logic arm_q, arm_d;
  // Arm stages reset high, so a pin held high through reset gives no edge
  localparam logic [NUM_TRIP:0] SYNC_RST = {`PSI_ARM_SYNC_RST, {NUM_TRIP{1'b0}}};

  always_comb
  begin
    s1_d = {arm_i, trip_i};
    s2_d = s1_q;
    s3_d = s2_q;
    flt_d = flt_q;
    for (int i = 0; i <= NUM_TRIP; i++)
    begin
      if (s2_q[i] == s3_q[i])
      begin
        flt_d[i] = s3_q[i];
      end
    end
    arm_d = flt_q[NUM_TRIP];
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (sys_rst_i)
    begin
      s1_q <= SYNC_RST;
      s2_q <= SYNC_RST;
      s3_q <= SYNC_RST;
      flt_q <= SYNC_RST;
      arm_q <= `PSI_ARM_SYNC_RST;
    end
    else
    begin
      s1_q <= s1_d;
      s2_q <= s2_d;
      s3_q <= s3_d;
      flt_q <= flt_d;
      arm_q <= arm_d;
    end
  end

  wire logic arm_lvl = flt_q[NUM_TRIP];
  wire logic arm_rise = arm_lvl & ~arm_q; // Low-to-high only
  wire logic [NUM_TRIP-1:0] trip_lvl = flt_q[NUM_TRIP-1:0];

  // ==========================================================
  // Registers
  // ==========================================================
  logic [1:0] ctrl_q, ctrl_d;
  logic [NUM_TRIP-1:0] tcfg_q, tcfg_d;
  logic [2:0] ist_q, ist_d, imsk_q, imsk_d;
  logic [31:0] rdata_q, rdata_d;
  logic [2:0] ev;

  // ==========================================================
  // Interlock state machine
  // ==========================================================
  psi_pkg::psi_state_t st_q, st_d;
  logic [CW-1:0] cnt_q, cnt_d;
  logic [NUM_TRIP-1:0] tlat_q, tlat_d;

  wire logic trip_hit = |(trip_lvl & tcfg_q); // Ignored lines drop out

  // Next state, settle counter and trip latch
  always_comb
  begin
    st_d = st_q;
    cnt_d = cnt_q;
    tlat_d = tlat_q | (trip_lvl & tcfg_q); // Latched until rearmed
    ev = 3'h0;
    unique case (st_q)
      psi_pkg::PSI_IDLE:
      begin
        if (arm_rise) // Only an edge arms, never a held level
        begin
          st_d = psi_pkg::PSI_SETTLE;
          cnt_d = '0;
          tlat_d = '0; // Disabled-to-enabled cycle clears trips
          ev[`PSI_IRQ_ARM] = 1'b1;
        end
      end
      psi_pkg::PSI_SETTLE:
      begin
        if (!arm_lvl)
        begin
          st_d = psi_pkg::PSI_IDLE;
        end
        else if (trip_hit)
        begin
          st_d = psi_pkg::PSI_TRIP;
          ev[`PSI_IRQ_TRIP] = 1'b1;
        end
        else if (cnt_q == CW'(SETTLE_CYC - 1)) // 100 ms elapsed
        begin
          st_d = psi_pkg::PSI_RUN;
          ev[`PSI_IRQ_RELEASE] = 1'b1;
        end
        else
        begin
          cnt_d = cnt_q + CW'(1); // Counts system clocks
        end
      end
      psi_pkg::PSI_RUN:
      begin
        if (!arm_lvl)
        begin
          st_d = psi_pkg::PSI_IDLE;
        end
        else if (trip_hit) // One-shot shutdown
        begin
          st_d = psi_pkg::PSI_TRIP;
          ev[`PSI_IRQ_TRIP] = 1'b1;
        end
      end
      psi_pkg::PSI_TRIP:
      begin
        // Stays shut until arm drops; a fresh edge is then needed
        if (!arm_lvl)
        begin
          st_d = psi_pkg::PSI_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (sys_rst_i)
    begin
      st_q <= psi_pkg::PSI_IDLE;
      cnt_q <= '0;
      tlat_q <= '0;
    end
    else
    begin
      st_q <= st_d;
      cnt_q <= cnt_d;
      tlat_q <= tlat_d;
    end
  end

  // ==========================================================
  // Output stage
  // ==========================================================
  logic [NUM_PWM-1:0] pwm_q, pwm_d;
  logic [NUM_HR-1:0] hr_q, hr_d, hroe_q, hroe_d;
  logic stat_q, stat_d, gde_q, gde_d, gdoe_q, gdoe_d;

  // Outputs are registered from the next state, so they change in the same cycle as the state
  always_comb
  begin
    logic run;
    logic armed;
    run = 1'b0;
    armed = 1'b0;
    if (!INTERLOCK_PRESENT)
    begin
      run = 1'b1; // No interlock: always enabled
      armed = 1'b1;
    end
    else
    begin
      run = (st_d == psi_pkg::PSI_RUN);
      armed = (st_d == psi_pkg::PSI_SETTLE) || run; // Set on arming, no wait
    end
    // PWM gating depends on state only, never on the pin
    pwm_d = run ? pwm_i : pwm_passive_i; // Passive when held off
    hroe_d = '0;
    if (run)
    begin
      hr_d = high_res_pwm_timer_i;
    end
    else if (INTERLOCK_PRESENT && st_d == psi_pkg::PSI_TRIP)
    begin
      hr_d = high_res_pwm_timer_fault_i; // Fault level per channel
      hroe_d = high_res_pwm_timer_fault_hiz_i;
    end
    else
    begin
      hr_d = high_res_pwm_timer_passive_i;
    end
    stat_d = run; // Rises together with the PWM
    // Active-low polarity bit 0 drives 0 when armed
    gde_d = ctrl_q[`PSI_CTRL_GDE_POL] ? armed : ~armed;
    gdoe_d = ~ctrl_q[`PSI_CTRL_GDE_EN]; // Unassigned pin stays released
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (sys_rst_i)
    begin
      pwm_q <= '0;
      hr_q <= '0;
      hroe_q <= '0;
      stat_q <= 1'b0;
      gde_q <= 1'b0;
      gdoe_q <= 1'b1;
    end
    else
    begin
      pwm_q <= pwm_d;
      hr_q <= hr_d;
      hroe_q <= hroe_d;
      stat_q <= stat_d;
      gde_q <= gde_d;
      gdoe_q <= gdoe_d;
    end
  end

  // ==========================================================
  // Register file
  // ==========================================================
  // Write-one-to-clear; a new event wins over a clear
  always_comb
  begin
    ctrl_d = ctrl_q;
    tcfg_d = tcfg_q;
    imsk_d = imsk_q;
    ist_d = ist_q;
    rdata_d = 32'h0;
    if (reg_wr_i)
    begin
      unique case (reg_addr_i)
        `PSI_ADDR_CTRL: ctrl_d = reg_wdata_i[1:0];
        `PSI_ADDR_TRIPCFG: tcfg_d = reg_wdata_i[NUM_TRIP-1:0];
        `PSI_ADDR_IRQ_STAT: ist_d = ist_q & ~reg_wdata_i[2:0];
        `PSI_ADDR_IRQ_MASK: imsk_d = reg_wdata_i[2:0];
        default: ;
      endcase
    end
    ist_d = ist_d | ev;
    if (reg_rd_i)
    begin
      unique case (reg_addr_i)
        `PSI_ADDR_CTRL: rdata_d[1:0] = ctrl_q;
        `PSI_ADDR_TRIPCFG: rdata_d[NUM_TRIP-1:0] = tcfg_q;
        `PSI_ADDR_STATUS: rdata_d = {{(32-3-NUM_TRIP){1'b0}}, tlat_q,
          (st_q == psi_pkg::PSI_TRIP), stat_q, (st_q != psi_pkg::PSI_IDLE)};
        `PSI_ADDR_IRQ_STAT: rdata_d[2:0] = ist_q;
        `PSI_ADDR_IRQ_MASK: rdata_d[2:0] = imsk_q;
        default: rdata_d = 32'h0; // Unmapped reads as zero
      endcase
    end
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (sys_rst_i)
    begin
      ctrl_q <= `PSI_CTRL_RST;
      tcfg_q <= `PSI_TRIPCFG_RST;
      imsk_q <= `PSI_MASK_RST;
      ist_q <= 3'h0;
      rdata_q <= 32'h0;
    end
    else
    begin
      ctrl_q <= ctrl_d;
      tcfg_q <= tcfg_d;
      imsk_q <= imsk_d;
      ist_q <= ist_d;
      rdata_q <= rdata_d;
    end
  end

  logic irq_q;
  always_ff @(posedge clk_sys_i)
  begin
    if (sys_rst_i)
    begin
      irq_q <= 1'b0;
    end
    else
    begin
      irq_q <= |(ist_d & imsk_d);
    end
  end

  assign reg_rdata_o = rdata_q;
  assign pwm_o = pwm_q;
  assign high_res_pwm_timer_o = hr_q;
  assign high_res_pwm_timer_oe_n_o = hroe_q;
  assign status_o = stat_q;
  assign gde_o = gde_q;
  assign gde_oe_n_o = gdoe_q;
  assign irq_o = irq_q;

  // ==========================================================
  // Checks
  // ==========================================================
  sequence settle_entry;
    INTERLOCK_PRESENT && st_q == psi_pkg::PSI_IDLE && arm_rise;
  endsequence

  a_arm_needs_edge: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    INTERLOCK_PRESENT && st_q == psi_pkg::PSI_IDLE && !arm_rise |=> !stat_q)
    else $error("status rose without arm edge");
  a_passive_off: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    !sys_rst_i && INTERLOCK_PRESENT && st_q == psi_pkg::PSI_IDLE |=> pwm_o == $past(pwm_passive_i))
    else $error("pwm not passive while held");
  a_gde_pol: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    settle_entry |=> gde_o == ctrl_q[`PSI_CTRL_GDE_POL])
    else $error("enable pin polarity wrong");
  a_gde_now: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    settle_entry ##1 st_q == psi_pkg::PSI_SETTLE |-> gde_o == ctrl_q[`PSI_CTRL_GDE_POL] && !stat_q)
    else $error("enable pin late or status high at arming");
  a_no_il: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    !sys_rst_i && !INTERLOCK_PRESENT |=> pwm_o == $past(pwm_i))
    else $error("pwm gated without interlock");
  a_trip_shut: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    INTERLOCK_PRESENT && st_q == psi_pkg::PSI_RUN && arm_lvl && trip_hit
      |=> st_q == psi_pkg::PSI_TRIP ##0 !status_o ##1 !status_o)
    else $error("trip did not shut down");
  a_trip_latch: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    st_q == psi_pkg::PSI_TRIP && arm_lvl |=> st_q == psi_pkg::PSI_TRIP)
    else $error("trip cleared without rearm");
  a_stat_pwm: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    INTERLOCK_PRESENT && $rose(status_o) |-> $past(st_d) == psi_pkg::PSI_RUN && $past(st_q) == psi_pkg::PSI_SETTLE)
    else $error("status rose outside release");
  a_gde_oe: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    !ctrl_q[`PSI_CTRL_GDE_EN] |=> gde_oe_n_o)
    else $error("unassigned pin driven");

endmodule : psi_interlock
`default_nettype wire

// ### hdl/psi_map.svh
`ifndef PSI_MAP_SVH
`define PSI_MAP_SVH

// Register byte addresses
`define PSI_ADDR_CTRL 8'h00
`define PSI_ADDR_TRIPCFG 8'h04
`define PSI_ADDR_STATUS 8'h08
`define PSI_ADDR_IRQ_STAT 8'h0c
`define PSI_ADDR_IRQ_MASK 8'h10

// Control field positions
`define PSI_CTRL_GDE_EN 0
`define PSI_CTRL_GDE_POL 1

// Status field positions
`define PSI_STAT_ARMED 0
`define PSI_STAT_RELEASED 1
`define PSI_STAT_TRIPPED 2

// Interrupt bits
`define PSI_IRQ_ARM 0
`define PSI_IRQ_RELEASE 1
`define PSI_IRQ_TRIP 2

// Reset values
`define PSI_CTRL_RST 2'h0
`define PSI_TRIPCFG_RST 7'h00
`define PSI_MASK_RST 3'h0
`define PSI_ARM_SYNC_RST 1'b1

// Settling time
`define PSI_SETTLE_MS 100
`define PSI_CLK_HZ 50000000
`define PSI_SETTLE_CYC ((`PSI_CLK_HZ / 1000) * `PSI_SETTLE_MS)

`endif

// ### hdl/psi_pkg.sv
package psi_pkg;

  // Interlock state
  typedef enum logic [1:0] {
    PSI_IDLE,
    PSI_SETTLE,
    PSI_RUN,
    PSI_TRIP
  } psi_state_t;

endpackage : psi_pkg

// ### verification/psi_drv_model.sv
`timescale 1ns/10ps
`default_nettype none
// ==========
// Gate driver and regulator reset on the far side
module psi_drv_model (
  // From the interlock
  input wire logic gde_i,
  input wire logic gde_oe_n_i,
  input wire logic status_i,
  input wire logic pol_i,
  // Far side view
  output logic drv_on_o,
  output logic reg_hold_o
);
  // Undriven pin falls to its safe pull level, never the last value
  assign drv_on_o = ((gde_oe_n_i ? ~pol_i : gde_i) == pol_i);
  // Regulator reset follows the status output, not the arm pin
  assign reg_hold_o = ~status_i;
endmodule : psi_drv_model
`default_nettype wire

// ### verification/psi_interlock_test.sv
`timescale 1ns/10ps
`default_nettype none
`include "psi_map.svh"
// ==========
// Interlock bench
module psi_interlock_test;
  localparam int SC = 20;
  logic clk_sys_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic [31:0] rdata;
  logic [31:0] r;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic arm = 1'b1;
  logic pol = 1'b0;
  logic [6:0] trip = 7'h00;
  logic [5:0] pwm = 6'h2d;
  logic [5:0] pas = 6'h12;
  logic [5:0] hr = 6'h35;
  logic [5:0] hpas = 6'h0a;
  logic [5:0] hflt = 6'h19;
  logic [5:0] hz = 6'h21;
  logic [5:0] pwm_o;
  logic [5:0] hr_o;
  logic [5:0] hr_oe_n;
  logic status, gde, gde_oe_n, irq, drv_on, hold;
  logic [5:0] pwm_free;
  logic status_free;
  int miscompares = 0;
  int samples_checked = 0;

  // Clock, 20 ns period
  always #10 clk_sys_i = ~clk_sys_i;

  // Short settle count keeps the run brief
  psi_interlock #(.SETTLE_CYC(SC)) u_psi_interlock (
    .clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i),
    .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd),
    .reg_rdata_o(rdata), .arm_i(arm), .trip_i(trip),
    .pwm_i(pwm), .pwm_passive_i(pas), .pwm_o(pwm_o),
    .high_res_pwm_timer_i(hr), .high_res_pwm_timer_passive_i(hpas),
    .high_res_pwm_timer_fault_i(hflt), .high_res_pwm_timer_fault_hiz_i(hz),
    .high_res_pwm_timer_o(hr_o), .high_res_pwm_timer_oe_n_o(hr_oe_n),
    .status_o(status), .gde_o(gde), .gde_oe_n_o(gde_oe_n), .irq_o(irq)
  );

  // Second copy built without the interlock: PWM must pass at all times
  psi_interlock #(.SETTLE_CYC(SC), .INTERLOCK_PRESENT(1'b0)) u_psi_interlock_free (
    .clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i),
    .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd),
    .reg_rdata_o(), .arm_i(arm), .trip_i(trip),
    .pwm_i(pwm), .pwm_passive_i(pas), .pwm_o(pwm_free),
    .high_res_pwm_timer_i(hr), .high_res_pwm_timer_passive_i(hpas),
    .high_res_pwm_timer_fault_i(hflt), .high_res_pwm_timer_fault_hiz_i(hz),
    .high_res_pwm_timer_o(), .high_res_pwm_timer_oe_n_o(),
    .status_o(status_free), .gde_o(), .gde_oe_n_o(), .irq_o()
  );

  psi_drv_model u_psi_drv_model (
    .gde_i(gde), .gde_oe_n_i(gde_oe_n), .status_i(status), .pol_i(pol),
    .drv_on_o(drv_on), .reg_hold_o(hold)
  );

  // ==========
  // Tasks
  task cmp(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      miscompares++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp

  task wrap_up;
    $display("checks %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : wrap_up

  task cyc(input int n);
    repeat (n) @(posedge clk_sys_i);
    #1;
  endtask : cyc

  task wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys_i);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk_sys_i);
    wr <= 1'b0;
  endtask : wr_reg

  // Read data stand only in the cycle after the strobe
  task rd_reg(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk_sys_i);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk_sys_i);
    rd <= 1'b0;
    #1;
    d = rdata;
  endtask : rd_reg

  task pulse_trip(input logic [6:0] t);
    @(posedge clk_sys_i);
    trip <= t;
    cyc(8);
    @(posedge clk_sys_i);
    trip <= 7'h00;
    cyc(8);
  endtask : pulse_trip

  // Disarm, then arm; tracks enable pin timing and PWM hold-off
  task arm_up(input logic [1:0] c);
    int n;
    int g;
    logic ok;
    g = -1;
    ok = 1'b1;
    wr_reg(`PSI_ADDR_CTRL, {30'h0, c});
    pol = c[1];
    @(posedge clk_sys_i);
    arm <= 1'b0;
    cyc(8);
    @(posedge clk_sys_i);
    arm <= 1'b1;
    for (n = 0; n < 200 && status !== 1'b1; n++)
    begin
      @(posedge clk_sys_i);
      #1;
      if (g < 0 && gde_oe_n === ~c[0] && (c[0] === 1'b0 || gde === c[1]))
        g = n;
      if (status !== 1'b1 && pwm_o !== pas)
        ok = 1'b0;
    end
    if (n == 200)
    begin
      miscompares++;
      wrap_up();
    end
    cmp(g >= 0 && g <= 6, 1);
    cmp(n >= SC && n <= SC + 8, 1);
    cmp(ok, 1);
    cmp(pwm_o, pwm);
    cmp(hr_o, hr);
    cmp(gde_oe_n, !c[0]);
    cmp(drv_on, c[0]);
    cmp(hold, 0);
    $display("arm test ctrl=%h done", c);
  endtask : arm_up

  // ==========
  // Main sequence
  initial
  begin
    repeat (12) @(posedge clk_sys_i);
    sys_rst_i <= 1'b0;
    cyc(40);
    cmp(status, 0);
    cmp(pwm_o, pas);
    cmp(pwm_free, pwm);
    cmp(status_free, 1);
    $display("reset test done");
    wr_reg(`PSI_ADDR_IRQ_MASK, 32'h4);
    wr_reg(`PSI_ADDR_TRIPCFG, 32'h2);
    rd_reg(8'h3c, r);
    cmp(r, 32'h0);
    arm_up(2'b01);
    arm_up(2'b11);
    arm_up(2'b00);
    cmp(irq, 0);
    pulse_trip(7'h01);
    cmp(status, 1);
    pulse_trip(7'h02);
    cmp(status, 0);
    cmp(pwm_o, pas);
    cmp(hr_o & ~hz, hflt & ~hz);
    cmp(hr_oe_n, hz);
    cmp(irq, 1);
    cmp(hold, 1);
    cmp(pwm_free, pwm);
    rd_reg(`PSI_ADDR_STATUS, r);
    cmp(r & 32'h3fe, 32'h14);
    rd_reg(`PSI_ADDR_IRQ_STAT, r);
    cmp(r, 32'h7);
    wr_reg(`PSI_ADDR_IRQ_STAT, 32'h7);
    cyc(2);
    cmp(irq, 0);
    cyc(40);
    cmp(status, 0);
    $display("trip test done");
    arm_up(2'b11);
    rd_reg(`PSI_ADDR_STATUS, r);
    cmp(r & 32'h3fe, 32'h2);
    wrap_up();
  end
endmodule : psi_interlock_test
`default_nettype wire
